//--- common/prs_pkg.sv
// Constants and types shared by the read-command sequencer
package prs_pkg;
    // APB byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] XFER_LEN_OFS = 8'h04;
    localparam logic [7:0] SETUP_OFS    = 8'h08;
    localparam logic [7:0] ERR_OFS      = 8'h0C;
    localparam logic [7:0] STATE_OFS    = 8'h10;
    localparam logic [7:0] INT_STAT_OFS = 8'h14;
    localparam logic [7:0] INT_CLR_OFS  = 8'h18;
    localparam logic [7:0] INT_EN_OFS   = 8'h1C;
    // Control register bits
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    // Interrupt bits
    localparam int INT_DONE_BIT  = 0;
    localparam int INT_ABORT_BIT = 1;
    localparam int INT_W         = 2;
    // Status byte fields
    localparam int BSY_BIT = 7;
    localparam int DRQ_BIT = 3;
    // Transfer sizes
    localparam int LEN_W         = 24;
    localparam int BLK_MAX_BYTES = 8192;
    // Reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [LEN_W-1:0] LEN_RST = 24'h00_0000;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;
    // Sequencer states
    typedef enum logic [2:0] {
        command_idle_state,
        read_block_prepare_state,
        read_setup_frame_state,
        read_data_send_state,
        read_abort_status_state
    } prs_state_t;
endpackage

//--- src/prs_pio_read_seq.sv
// Device-side sequencer for PIO read commands, with APB registers
`timescale 1ns/1ns
// What this block does
// - Start or owed blocks enter block preparation
// - Ready block moves to PIO Setup request
// - Abort in preparation goes to error status
// - Setup initial status: BSY zero, DRQ one
// - Every Setup frame carries interrupt bit one
// - Last block: ending status BSY zero
// - More blocks: ending BSY one, DRQ zero
// - Setup frame sent advances to data send
// - Request one Data frame for the block
// - All data sent returns straight to idle
// - Data remaining after an 8KB block: prepare again
// - Error state sends Register frame, interrupt one
// - Register frame sent ends command, idle
module prs_pio_read_seq #(
    parameter int BLK_MAX = prs_pkg::BLK_MAX_BYTES
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    blk_ready,
    input  wire logic                    blk_error,
    output logic                         blk_prepare,
    output logic                         setup_req,
    output logic      [7:0]              setup_init_status,
    output logic      [7:0]              setup_end_status,
    output logic      [23:0]             setup_regs,
    output logic                         setup_ibit,
    output logic      [prs_pkg::LEN_W-1:0] setup_count,
    input  wire logic                    setup_done,
    output logic                         data_req,
    output logic      [prs_pkg::LEN_W-1:0] data_count,
    input  wire logic                    data_done,
    output logic                         regfis_req,
    output logic      [31:0]             regfis_regs,
    output logic                         regfis_ibit,
    input  wire logic                    regfis_done,
    output logic                         irq
);
    localparam int LW = prs_pkg::LEN_W;

    prs_pkg::prs_state_t state_reg;
    prs_pkg::prs_state_t state_next;
    logic [LW-1:0]       len_reg;
    logic [LW-1:0]       remain_reg;
    logic [LW-1:0]       remain_next;
    logic [LW-1:0]       blk_reg;
    logic [LW-1:0]       blk_next;
    logic                last_reg;
    logic [31:0]         setup_cfg_reg;
    logic [31:0]         err_cfg_reg;
    logic                abort_req_reg;
    logic [prs_pkg::INT_W-1:0] int_stat_reg;
    logic [prs_pkg::INT_W-1:0] int_en_reg;
    logic [prs_pkg::INT_W-1:0] int_set;
    logic [31:0]         prdata_next;

    // APB decode
    wire       apb_wr     = psel & penable & pwrite;
    wire       rd_setup   = psel & ~penable & ~pwrite;
    wire       hit_ctrl   = paddr == prs_pkg::CTRL_OFS;
    wire       hit_len    = paddr == prs_pkg::XFER_LEN_OFS;
    wire       hit_setup  = paddr == prs_pkg::SETUP_OFS;
    wire       hit_err    = paddr == prs_pkg::ERR_OFS;
    wire       hit_state  = paddr == prs_pkg::STATE_OFS;
    wire       hit_istat  = paddr == prs_pkg::INT_STAT_OFS;
    wire       hit_iclr   = paddr == prs_pkg::INT_CLR_OFS;
    wire       hit_ien    = paddr == prs_pkg::INT_EN_OFS;
    wire       hit_any    = hit_ctrl | hit_len | hit_setup | hit_err |
                            hit_state | hit_istat | hit_iclr | hit_ien;
    wire       wr_ctrl    = apb_wr & hit_ctrl;
    wire       is_idle    = state_reg == prs_pkg::command_idle_state;
    wire       start_cmd  = wr_ctrl & pwdata[prs_pkg::CTRL_START_BIT] &
                            is_idle & (len_reg != prs_pkg::LEN_RST);
    wire       abort_wr   = wr_ctrl & pwdata[prs_pkg::CTRL_ABORT_BIT] &
                            ~is_idle;
    wire       in_prep    = state_reg == prs_pkg::read_block_prepare_state;
    wire       abort_now  = in_prep & (blk_error | abort_req_reg);
    wire       blk_go     = in_prep & ~abort_now & blk_ready;
    wire       data_sent  = data_req & data_done;
    wire       cmd_done   = data_sent & last_reg;
    wire       abort_end  = regfis_req & regfis_done;

    // No wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // Read mux; write-only and unmapped words read as zero
    assign prdata_next =
        hit_ctrl  ? {31'h0000_0000, ~is_idle} :
        hit_len   ? {8'h00, len_reg} :
        hit_setup ? setup_cfg_reg :
        hit_err   ? err_cfg_reg :
        hit_state ? {5'h00, state_reg, remain_reg} :
        hit_istat ? {30'h0000_0000, int_stat_reg} :
        hit_ien   ? {30'h0000_0000, int_en_reg} :
        prs_pkg::WORD_RST;

    // Block size is capped so no Data frame exceeds the limit
    assign blk_next = (remain_reg > LW'(BLK_MAX)) ? LW'(BLK_MAX)
                                                  : remain_reg;

    // Next state of the sequencer
    always_comb
    begin
        state_next  = state_reg;
        remain_next = remain_reg;
        case (state_reg)
            prs_pkg::command_idle_state:
            begin
                if (start_cmd)
                begin
                    state_next  = prs_pkg::read_block_prepare_state;
                    remain_next = len_reg;
                end
            end
            prs_pkg::read_block_prepare_state:
            begin
                if (abort_now)
                    state_next = prs_pkg::read_abort_status_state;
                else if (blk_ready)
                    state_next = prs_pkg::read_setup_frame_state;
            end
            prs_pkg::read_setup_frame_state:
            begin
                if (setup_done)
                    state_next = prs_pkg::read_data_send_state;
            end
            prs_pkg::read_data_send_state:
            begin
                if (data_done)
                begin
                    remain_next = remain_reg - blk_reg;
                    if (last_reg)
                        state_next = prs_pkg::command_idle_state;
                    else
                        state_next = prs_pkg::read_block_prepare_state;
                end
            end
            prs_pkg::read_abort_status_state:
            begin
                if (regfis_done)
                    state_next = prs_pkg::command_idle_state;
            end
            default:
                state_next = prs_pkg::command_idle_state;
        endcase
    end

    // State and byte accounting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg  <= prs_pkg::command_idle_state;
            remain_reg <= prs_pkg::LEN_RST;
        end
        else
        begin
            state_reg  <= state_next;
            remain_reg <= remain_next;
        end
    end

    // Latch the block size once, so frame contents stay steady
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blk_reg  <= prs_pkg::LEN_RST;
            last_reg <= 1'b0;
        end
        else if (blk_go)
        begin
            blk_reg  <= blk_next;
            last_reg <= blk_next == remain_reg;
        end
    end

    // Setup frame status bytes, captured with the block size
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            setup_init_status <= 8'h00;
            setup_end_status  <= 8'h00;
            setup_regs        <= 24'h00_0000;
        end
        else if (blk_go)
        begin
            setup_init_status <= setup_cfg_reg[7:0];
            setup_init_status[prs_pkg::BSY_BIT] <= 1'b0;
            setup_init_status[prs_pkg::DRQ_BIT] <= 1'b1;
            setup_end_status  <= setup_cfg_reg[7:0];
            setup_end_status[prs_pkg::DRQ_BIT]  <= 1'b0;
            // Final block lets the host see the device not busy
            setup_end_status[prs_pkg::BSY_BIT] <=
                blk_next != remain_reg;
            setup_regs <= setup_cfg_reg[31:8];
        end
    end

    // Frame requests follow the state directly
    assign setup_req   = state_reg == prs_pkg::read_setup_frame_state;
    assign data_req    = state_reg == prs_pkg::read_data_send_state;
    assign regfis_req  = state_reg ==
                         prs_pkg::read_abort_status_state;
    assign blk_prepare = in_prep;
    assign setup_ibit  = 1'b1;
    assign regfis_ibit = 1'b1;
    assign setup_count = blk_reg;
    assign data_count  = blk_reg;

    // Error register content is frozen for the whole abort frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            regfis_regs <= prs_pkg::WORD_RST;
        else if (abort_now)
            regfis_regs <= err_cfg_reg;
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            len_reg       <= prs_pkg::LEN_RST;
            setup_cfg_reg <= prs_pkg::WORD_RST;
            err_cfg_reg   <= prs_pkg::WORD_RST;
            int_en_reg    <= prs_pkg::INT_RST;
        end
        else if (apb_wr)
        begin
            if (hit_len)
                len_reg <= pwdata[LW-1:0];
            if (hit_setup)
                setup_cfg_reg <= pwdata;
            if (hit_err)
                err_cfg_reg <= pwdata;
            if (hit_ien)
                int_en_reg <= pwdata[prs_pkg::INT_W-1:0];
        end
    end

    // Software abort waits for the next preparation point
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            abort_req_reg <= 1'b0;
        else if (abort_wr)
            abort_req_reg <= 1'b1;
        else if (abort_now | is_idle)
            abort_req_reg <= 1'b0;
    end

    // Sticky events; a set in the clearing cycle wins
    assign int_set[prs_pkg::INT_DONE_BIT]  = cmd_done;
    assign int_set[prs_pkg::INT_ABORT_BIT] = abort_end;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_stat_reg <= prs_pkg::INT_RST;
        else if (apb_wr & hit_iclr)
            int_stat_reg <= (int_stat_reg &
                             ~pwdata[prs_pkg::INT_W-1:0]) | int_set;
        else
            int_stat_reg <= int_stat_reg | int_set;
    end
    assign irq = |(int_stat_reg & int_en_reg);

    // Read data captured in the setup cycle, so it stands at the ready edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= prs_pkg::WORD_RST;
        else if (rd_setup)
            prdata <= prdata_next;
    end

    // Checks
    sequence s_setup_sent;
        setup_req && setup_done;
    endsequence
    sequence s_data_sent;
        data_req && data_done;
    endsequence
    a_start_prepare: assert property (@(posedge pclk)
        disable iff (!presetn) start_cmd |=> blk_prepare && !setup_req)
        else $error("start did not enter preparation");
    a_ready_setup: assert property (@(posedge pclk)
        disable iff (!presetn) blk_go |=> setup_req)
        else $error("ready block did not request setup");
    a_abort_error: assert property (@(posedge pclk)
        disable iff (!presetn)
        abort_now |=> regfis_req && !setup_req ##0
        regfis_regs == $past(err_cfg_reg))
        else $error("abort did not reach error status");
    a_init_status: assert property (@(posedge pclk)
        disable iff (!presetn) setup_req |->
        !setup_init_status[prs_pkg::BSY_BIT] &&
        setup_init_status[prs_pkg::DRQ_BIT] && setup_ibit)
        else $error("bad initial status or I bit");
    a_end_last: assert property (@(posedge pclk)
        disable iff (!presetn) setup_req && setup_count == remain_reg
        |-> !setup_end_status[prs_pkg::BSY_BIT])
        else $error("last block ends busy");
    a_end_more: assert property (@(posedge pclk)
        disable iff (!presetn) setup_req && setup_count < remain_reg
        |-> setup_end_status[prs_pkg::BSY_BIT] &&
        !setup_end_status[prs_pkg::DRQ_BIT])
        else $error("non-final block end status wrong");
    a_setup_data: assert property (@(posedge pclk)
        disable iff (!presetn) s_setup_sent |=> data_req &&
        data_count == $past(setup_count))
        else $error("setup sent but no data request");
    a_done_idle: assert property (@(posedge pclk)
        disable iff (!presetn) s_data_sent ##0 last_reg |=>
        is_idle && remain_reg == 24'h00_0000 && !regfis_req)
        else $error("final data frame did not end command");
    a_more_prep: assert property (@(posedge pclk)
        disable iff (!presetn) s_data_sent ##0 !last_reg |=>
        blk_prepare && remain_reg == $past(remain_reg) - $past(data_count))
        else $error("remaining data not re-prepared");
    a_blk_limit: assert property (@(posedge pclk)
        disable iff (!presetn) data_req |-> data_count <= LW'(BLK_MAX))
        else $error("data frame above block limit");
    a_reg_idle: assert property (@(posedge pclk)
        disable iff (!presetn) abort_end |=> is_idle &&
        int_stat_reg[prs_pkg::INT_ABORT_BIT])
        else $error("error frame did not end command");
    a_req_hold: assert property (@(posedge pclk)
        disable iff (!presetn) setup_req && !setup_done |=>
        setup_req && $stable(setup_count) &&
        $stable(setup_end_status))
        else $error("setup request dropped before done");
endmodule // prs_pio_read_seq

//--- verif/prs_xport_model.sv
// Transport-layer stand-in that completes frame requests after a lag
`timescale 1ns/1ns
module prs_xport_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] lag,
    input  wire logic       setup_req,
    input  wire logic       data_req,
    input  wire logic       regfis_req,
    output logic            setup_done,
    output logic            data_done,
    output logic            regfis_done
);
    logic [3:0] wait_reg;
    logic       any_req;
    logic       any_done;

    // Completion only while a request stands, so a dropped one is never acked
    assign any_req  = setup_req | data_req | regfis_req;
    assign any_done = setup_done | data_done | regfis_done;

    // One-cycle done pulse once the request has waited lag cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_reg    <= 4'h0;
            setup_done  <= 1'b0;
            data_done   <= 1'b0;
            regfis_done <= 1'b0;
        end
        else
        begin
            setup_done  <= 1'b0;
            data_done   <= 1'b0;
            regfis_done <= 1'b0;
            if (!any_req || any_done)
                wait_reg <= 4'h0; // No request or pulse just given: wait for next request
            else if (wait_reg >= lag)
            begin
                setup_done  <= setup_req;
                data_done   <= data_req;
                regfis_done <= regfis_req;
                wait_reg    <= 4'h0;
            end
            else
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // prs_xport_model

//--- verif/testbench.sv
// Self-checking bench for the PIO read-command sequencer
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    err_total++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end end
module testbench;
    localparam int BLK = 16;
    typedef struct packed
    {
        logic [23:0] len;
        logic [3:0]  lag;
        logic [7:0]  stat;
        logic [3:0]  nblk;
    } prs_row_t;
    // Lengths straddle the block cap: exact, cap plus one, several caps
    localparam prs_row_t ROWS [5] = '{'{24'h10, 4'h0, 8'h41, 4'h1},
        '{24'h11, 4'h2, 8'h50, 4'h2}, '{24'h30, 4'h0, 8'hFF, 4'h3},
        '{24'h05, 4'h5, 8'h00, 4'h1}, '{24'h21, 4'h1, 8'h81, 4'h3}};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, setup_init_status, setup_end_status;
    logic [31:0] pwdata, prdata, regfis_regs, rd, setup_val, err_val;
    logic        blk_ready, blk_error, blk_prepare, setup_req, setup_ibit;
    logic        setup_done, data_req, data_done, regfis_req, regfis_done;
    logic        regfis_ibit, irq, slv;
    logic [23:0] setup_regs, setup_count, data_count, exp_rem, exp_cnt;
    logic [7:0]  e_init, e_end;
    logic [3:0]  lag;
    logic [1:0]  prev_req;
    logic [87:0] prev_cont, cur_cont;
    int          err_total, n_tests, nblk, nerr;

    prs_pio_read_seq #(.BLK_MAX(BLK)) u_prs_pio_read_seq (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .blk_ready(blk_ready), .blk_error(blk_error),
        .blk_prepare(blk_prepare), .setup_req(setup_req),
        .setup_init_status(setup_init_status),
        .setup_end_status(setup_end_status), .setup_regs(setup_regs),
        .setup_ibit(setup_ibit), .setup_count(setup_count),
        .setup_done(setup_done), .data_req(data_req),
        .data_count(data_count), .data_done(data_done),
        .regfis_req(regfis_req), .regfis_regs(regfis_regs),
        .regfis_ibit(regfis_ibit), .regfis_done(regfis_done), .irq(irq));
    prs_xport_model u_prs_xport_model (.pclk(pclk), .presetn(presetn),
        .lag(lag), .setup_req(setup_req), .data_req(data_req),
        .regfis_req(regfis_req), .setup_done(setup_done),
        .data_done(data_done), .regfis_done(regfis_done));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic close_out;
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; data and error flag taken at the ready edge
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        wait_on(3);
        slv = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Bounded wait: 0 irq, 1 error frame sent, 2 data request, 3 ready
    task automatic wait_on(input int mode);
        int k;
        k = 0;
        while (k < 400 && ((mode == 0) ? irq : (mode == 1) ?
               logic'(nerr != 0) : (mode == 2) ? data_req : pready) !== 1'b1)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 400)
        begin
            err_total++;
            $display("Error wait %0d expected 1 seen 0", mode);
            close_out;
        end
    endtask

    // Score every completed frame against the block walk
    always @(posedge pclk)
    begin
        e_init = (setup_val[7:0] & 8'h77) | 8'h08;
        e_end = (setup_val[7:0] & 8'h77) | ((exp_rem > BLK) ? 8'h80 : 8'h00);
        if (setup_req && setup_done)
        begin
            exp_cnt = (exp_rem > BLK) ? 24'(BLK) : exp_rem;
            `CHK("setup_count", exp_cnt, setup_count)
            `CHK("init_status", e_init, setup_init_status)
            `CHK("end_status", e_end, setup_end_status)
            `CHK("setup_regs", setup_val[31:8], setup_regs)
            `CHK("setup_ibit", 1'b1, setup_ibit)
        end
        if (data_req && data_done)
        begin
            `CHK("data_count", exp_cnt, data_count)
            exp_rem = exp_rem - exp_cnt;
            nblk++;
        end
        if (regfis_req && regfis_done)
        begin
            `CHK("regfis_regs", err_val, regfis_regs)
            `CHK("regfis_ibit", 1'b1, regfis_ibit)
            nerr++;
        end
        cur_cont = {setup_init_status, setup_end_status, setup_regs,
                    setup_count, data_count};
        if (({setup_req, data_req} & prev_req) != 2'b00)
            `CHK("held", prev_cont, cur_cont)
        prev_req = {setup_req, data_req};
        prev_cont = cur_cont;
    end

    initial
    begin
        {err_total, n_tests, nblk, nerr} = '0;
        {psel, penable, pwrite, blk_ready, blk_error, presetn} = '0;
        {paddr, pwdata, lag, exp_rem, setup_val} = '0;
        err_val = 32'h5A01_0451;
        repeat (20) @(posedge pclk);
        `CHK("rst_req", 3'h0, {setup_req, data_req, regfis_req})
        `CHK("rst_ibit", 1'b1, setup_ibit)
        `CHK("rst_out", 4'h1, {irq, blk_prepare, pslverr, pready})
        presetn <= 1'b1;
        @(posedge pclk);
        apb(8'h20, 1'b1, 32'hFFFF_FFFF);
        apb(8'h20, 1'b0, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {slv, rd})
        apb(prs_pkg::ERR_OFS, 1'b1, err_val);
        apb(prs_pkg::INT_EN_OFS, 1'b1, 32'h1);
        blk_ready <= 1'b1;
        foreach (ROWS[i])
        begin
            lag <= ROWS[i].lag;
            setup_val = {16'hC3A5, 8'(i), ROWS[i].stat};
            apb(prs_pkg::SETUP_OFS, 1'b1, setup_val);
            apb(prs_pkg::XFER_LEN_OFS, 1'b1, {8'h00, ROWS[i].len});
            {nblk, nerr} = '0;
            exp_rem = ROWS[i].len;
            apb(prs_pkg::CTRL_OFS, 1'b1, 32'h1);
            wait_on(0);
            `CHK("blocks", ROWS[i].nblk, 4'(nblk))
            `CHK("left", 24'h0, exp_rem)
            `CHK("no_status", 4'h0, 4'(nerr))
            `CHK("idle", 1'b0, blk_prepare)
            apb(prs_pkg::INT_STAT_OFS, 1'b0, 32'h0);
            `CHK("int_stat", 32'h1, rd)
            apb(prs_pkg::INT_CLR_OFS, 1'b1, 32'h1);
            `CHK("irq_clr", 1'b0, irq)
        end
        // Stalled data path, then a data-path error, with the irq masked
        apb(prs_pkg::INT_EN_OFS, 1'b1, 32'h0);
        blk_ready <= 1'b0;
        lag <= 4'h2;
        {nblk, nerr} = '0;
        apb(prs_pkg::CTRL_OFS, 1'b1, 32'h1);
        repeat (4) @(posedge pclk);
        `CHK("stall_prep", 2'b10, {blk_prepare, setup_req})
        apb(prs_pkg::STATE_OFS, 1'b0, 32'h0);
        `CHK("stall_state", 32'h0100_0021, rd)
        blk_error <= 1'b1;
        wait_on(1);
        blk_error <= 1'b0;
        @(posedge pclk);
        `CHK("abort_blocks", 4'h0, 4'(nblk))
        `CHK("abort_idle", 3'h0, {regfis_req, blk_prepare, irq})
        apb(prs_pkg::INT_STAT_OFS, 1'b0, 32'h0);
        `CHK("abort_stat", 32'h2, rd)
        apb(prs_pkg::INT_EN_OFS, 1'b1, 32'h3);
        `CHK("irq_on", 1'b1, irq)
        apb(prs_pkg::INT_CLR_OFS, 1'b1, 32'h2);
        `CHK("irq_off", 1'b0, irq)
        // Software abort while the first of three blocks is in flight
        blk_ready <= 1'b1;
        lag <= 4'h3;
        {nblk, nerr} = '0;
        exp_rem = 24'h21;
        apb(prs_pkg::CTRL_OFS, 1'b1, 32'h1);
        wait_on(2);
        apb(prs_pkg::CTRL_OFS, 1'b1, 32'h2);
        wait_on(1);
        `CHK("sw_abort", 4'h1, 4'(nblk))
        close_out;
    end
endmodule // testbench
